/* File: rtl/etc_pkg.sv */
// package for the eight bit timer/counter core: offsets, fields, modes
// assumes one 10 MHz clock and a plain strobe register port
package etc_pkg;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [3:0] ADDR_CTRL_A  = 4'h0;
    localparam logic [3:0] ADDR_CTRL_B  = 4'h1;
    localparam logic [3:0] ADDR_COUNT   = 4'h2;
    localparam logic [3:0] ADDR_CMP_A   = 4'h3;
    localparam logic [3:0] ADDR_CMP_B   = 4'h4;
    localparam logic [3:0] ADDR_MASK    = 4'h5;
    localparam logic [3:0] ADDR_FLAG    = 4'h6;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int CTRLA_WGM0_POS = 0;
    localparam int CTRLA_WGM1_POS = 1;
    localparam int CTRLA_COMB_POS = 4;
    localparam int CTRLA_COMA_POS = 6;
    localparam int CTRLB_CS_POS   = 0;
    localparam int CTRLB_WGM2_POS = 3;
    localparam int CTRLB_FOCB_POS = 6;
    localparam int CTRLB_FOCA_POS = 7;
    localparam int FLAG_OVF_POS   = 0;
    localparam int FLAG_CMPA_POS  = 1;
    localparam int FLAG_CMPB_POS  = 2;

    // ------------------------------------------------------------
    // values and reset values
    // ------------------------------------------------------------
    localparam logic [7:0] VAL_BOTTOM = 8'h00;
    localparam logic [7:0] VAL_MAX    = 8'hFF;
    localparam logic [7:0] RST_BYTE   = 8'h00;
    localparam logic [2:0] CS_STOPPED = 3'h0;
    localparam logic [2:0] CS_EXT_FALL = 3'h6;
    localparam logic [2:0] CS_EXT_RISE = 3'h7;

    // prescaler taps in clock cycles
    localparam int PRE_DIV8    = 8;
    localparam int PRE_DIV64   = 64;
    localparam int PRE_DIV256  = 256;
    localparam int PRE_DIV1024 = 1024;
    localparam int PRE_WIDTH   = 10;

    // ------------------------------------------------------------
    // waveform modes
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        WGM_NORMAL    = 3'h0,
        WGM_PC_FF     = 3'h1,
        WGM_CTC       = 3'h2,
        WGM_FAST_FF   = 3'h3,
        WGM_RSVD4     = 3'h4,
        WGM_PC_OCRA   = 3'h5,
        WGM_RSVD6     = 3'h6,
        WGM_FAST_OCRA = 3'h7
    } etc_wgm_type;

    typedef struct packed {
        logic       match;
        logic       force_hit;
        logic [1:0] com;
    } etc_unit_type;

endpackage : etc_pkg

/* File: rtl/etc_prescaler.sv */
// prescaler and clock select: one-cycle timer tick enable
// assumes the count input is already synchronous to clk
module etc_prescaler (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       nrst,
    // selection
    input  wire logic [2:0] clockSourceSelect,
    input  wire logic       externalCountInput,
    // tick
    output logic            timerTick
);

    logic [etc_pkg::PRE_WIDTH-1:0] preCnt_q;
    logic                          extLast_q;
    logic                          extRise;
    logic                          extFall;

    // ------------------------------------------------------------
    // free running prescaler
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            preCnt_q <= '0;
        end else begin
            preCnt_q <= preCnt_q + 1'b1;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            extLast_q <= 1'b0;
        end else begin
            extLast_q <= externalCountInput;
        end
    end

    assign extRise = externalCountInput & ~extLast_q;
    assign extFall = ~externalCountInput & extLast_q;

    // ------------------------------------------------------------
    // source and edge selection
    // ------------------------------------------------------------
    always_comb begin
        unique case (clockSourceSelect)
            3'h0: timerTick = 1'b0;
            3'h1: timerTick = 1'b1;
            3'h2: timerTick = &preCnt_q[2:0];
            3'h3: timerTick = &preCnt_q[5:0];
            3'h4: timerTick = &preCnt_q[7:0];
            3'h5: timerTick = &preCnt_q[9:0];
            3'h6: timerTick = extFall;
            3'h7: timerTick = extRise;
        endcase
    end

endmodule : etc_prescaler

/* File: rtl/etc_timer_core.sv */
// top of the timer/counter: register port, counter, compare, flags
// assumes synchronous inputs, single clk, one-cycle strobes
module etc_timer_core (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       nrst,
    // register port
    input  wire logic [3:0] regAddr,
    input  wire logic [7:0] regWdata,
    input  wire logic       regWrite,
    input  wire logic       regRead,
    output logic      [7:0] regRdata,
    // pins
    input  wire logic       externalCountInput,
    output logic            compareAOutput,
    output logic            compareBOutput,
    // interrupt requests
    output logic            overflowIrq,
    output logic            compareAIrq,
    output logic            compareBIrq
);

    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    logic [7:0] timerControlA_q;
    logic [7:0] timerControlB_q;
    logic [7:0] counterValue_q;
    logic [7:0] compareABuf_q;
    logic [7:0] compareBBuf_q;
    logic [7:0] compareAValue_q;
    logic [7:0] compareBValue_q;
    logic [2:0] timerMask_q;
    logic [2:0] timerFlag_q;
    logic       countDown_q;
    logic       blockMatch_q;

    logic       timerTick;
    logic [2:0] waveformModeField;
    logic [2:0] clockSourceSelect;
    logic       isPwm;
    logic       isPhase;
    logic       topIsCmpA;
    logic [7:0] topValue;
    logic       atTop;
    logic       atBottom;
    logic       wrCount;
    logic       tovSet;
    logic       loadAtTop;
    logic       loadAtBottom;
    logic       loadCompare;
    logic [7:0] counterValue_d;
    logic       countDown_d;
    logic       forceA;
    logic       forceB;
    logic       equalA;
    logic       equalB;
    etc_pkg::etc_unit_type unitA;
    etc_pkg::etc_unit_type unitB;

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    assign waveformModeField = {
        timerControlB_q[etc_pkg::CTRLB_WGM2_POS],
        timerControlA_q[etc_pkg::CTRLA_WGM1_POS],
        timerControlA_q[etc_pkg::CTRLA_WGM0_POS]};
    assign clockSourceSelect =
        timerControlB_q[etc_pkg::CTRLB_CS_POS +: 3];
    assign isPwm     = waveformModeField[0];
    assign isPhase   = waveformModeField[1:0] == 2'b01;
    assign topIsCmpA = waveformModeField == etc_pkg::WGM_CTC ||
                       waveformModeField[2];
    assign topValue  = topIsCmpA ? compareAValue_q
                                 : etc_pkg::VAL_MAX;
    assign atTop     = counterValue_q == topValue;
    assign atBottom  = counterValue_q == etc_pkg::VAL_BOTTOM;
    assign wrCount   = regWrite && regAddr == etc_pkg::ADDR_COUNT;
    assign forceA    = regWrite && regAddr == etc_pkg::ADDR_CTRL_B &&
                       regWdata[etc_pkg::CTRLB_FOCA_POS] && !isPwm;
    assign forceB    = regWrite && regAddr == etc_pkg::ADDR_CTRL_B &&
                       regWdata[etc_pkg::CTRLB_FOCB_POS] && !isPwm;

    etc_prescaler u_prescaler (
        .clk                (clk),
        .nrst               (nrst),
        .clockSourceSelect  (clockSourceSelect),
        .externalCountInput (externalCountInput),
        .timerTick          (timerTick)
    );

    // ------------------------------------------------------------
    // counter next value
    // ------------------------------------------------------------
    always_comb begin
        counterValue_d = counterValue_q;
        countDown_d    = countDown_q;
        tovSet         = 1'b0;
        if (timerTick) begin
            if (isPhase) begin
                if (countDown_q) begin
                    counterValue_d = counterValue_q - 8'h01;
                    if (counterValue_q == 8'h01) begin
                        countDown_d = 1'b0;
                    end
                end else begin
                    counterValue_d = counterValue_q + 8'h01;
                    if (counterValue_d == topValue) begin
                        countDown_d = 1'b1;
                    end
                end
                tovSet = atBottom && !countDown_q;
            end else if (atTop && topIsCmpA) begin
                counterValue_d = etc_pkg::VAL_BOTTOM;
                tovSet = waveformModeField[0];
            end else begin
                counterValue_d = counterValue_q + 8'h01;
                tovSet = counterValue_q == etc_pkg::VAL_MAX;
            end
        end
        if (wrCount) begin
            counterValue_d = regWdata;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            counterValue_q <= etc_pkg::RST_BYTE;
            countDown_q    <= 1'b0;
        end else begin
            counterValue_q <= counterValue_d;
            countDown_q    <= countDown_d;
        end
    end

    // ------------------------------------------------------------
    // control and mask registers
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            timerControlA_q <= etc_pkg::RST_BYTE;
            timerControlB_q <= etc_pkg::RST_BYTE;
            timerMask_q     <= 3'h0;
        end else if (regWrite) begin
            if (regAddr == etc_pkg::ADDR_CTRL_A) begin
                timerControlA_q <= regWdata & 8'hF3;
            end
            if (regAddr == etc_pkg::ADDR_CTRL_B) begin
                timerControlB_q <= regWdata & 8'h0F;
            end
            if (regAddr == etc_pkg::ADDR_MASK) begin
                timerMask_q <= regWdata[2:0];
            end
        end
    end

    // ------------------------------------------------------------
    // compare buffers and active values
    // ------------------------------------------------------------
    assign loadAtTop    = isPwm && !isPhase && timerTick && atBottom;
    assign loadAtBottom = isPhase && timerTick && atTop;
    assign loadCompare  = !isPwm || loadAtTop || loadAtBottom;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            compareABuf_q <= etc_pkg::RST_BYTE;
            compareBBuf_q <= etc_pkg::RST_BYTE;
        end else if (regWrite) begin
            if (regAddr == etc_pkg::ADDR_CMP_A) begin
                compareABuf_q <= regWdata;
            end
            if (regAddr == etc_pkg::ADDR_CMP_B) begin
                compareBBuf_q <= regWdata;
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            compareAValue_q <= etc_pkg::RST_BYTE;
            compareBValue_q <= etc_pkg::RST_BYTE;
        end else if (loadCompare) begin
            compareAValue_q <= compareABuf_q;
            compareBValue_q <= compareBBuf_q;
        end
    end

    // ------------------------------------------------------------
    // compare and flags
    // ------------------------------------------------------------
    assign equalA = counterValue_q == compareAValue_q;
    assign equalB = counterValue_q == compareBValue_q;

    // a counter write hides the compare result up to the next tick
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            blockMatch_q <= 1'b0;
        end else if (wrCount) begin
            blockMatch_q <= 1'b1;
        end else if (timerTick) begin
            blockMatch_q <= 1'b0;
        end
    end

    assign unitA = '{match: equalA && !blockMatch_q,
                     force_hit: forceA,
                     com: timerControlA_q[etc_pkg::CTRLA_COMA_POS +: 2]};
    assign unitB = '{match: equalB && !blockMatch_q,
                     force_hit: forceB,
                     com: timerControlA_q[etc_pkg::CTRLA_COMB_POS +: 2]};

    // set wins over a software write-one clear
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            timerFlag_q <= 3'h0;
        end else begin
            for (int i = 0; i < 3; i++) begin
                if (regWrite && regAddr == etc_pkg::ADDR_FLAG &&
                    regWdata[i]) begin
                    timerFlag_q[i] <= 1'b0;
                end
            end
            if (tovSet) begin
                timerFlag_q[etc_pkg::FLAG_OVF_POS] <= 1'b1;
            end
            if (timerTick && unitA.match) begin
                timerFlag_q[etc_pkg::FLAG_CMPA_POS] <= 1'b1;
            end
            if (timerTick && unitB.match) begin
                timerFlag_q[etc_pkg::FLAG_CMPB_POS] <= 1'b1;
            end
        end
    end

    assign overflowIrq = timerFlag_q[etc_pkg::FLAG_OVF_POS] &
                         timerMask_q[etc_pkg::FLAG_OVF_POS];
    assign compareAIrq = timerFlag_q[etc_pkg::FLAG_CMPA_POS] &
                         timerMask_q[etc_pkg::FLAG_CMPA_POS];
    assign compareBIrq = timerFlag_q[etc_pkg::FLAG_CMPB_POS] &
                         timerMask_q[etc_pkg::FLAG_CMPB_POS];

    // ------------------------------------------------------------
    // waveform outputs
    // ------------------------------------------------------------
    etc_waveform u_wave_a (
        .clk               (clk),
        .nrst              (nrst),
        .waveformModeField (waveformModeField),
        .unitIn            (unitA),
        .tick              (timerTick),
        .atTop             (atTop),
        .atBottom          (atBottom),
        .countDown         (countDown_q),
        .compareOutput     (compareAOutput)
    );

    etc_waveform u_wave_b (
        .clk               (clk),
        .nrst              (nrst),
        .waveformModeField (waveformModeField),
        .unitIn            (unitB),
        .tick              (timerTick),
        .atTop             (atTop),
        .atBottom          (atBottom),
        .countDown         (countDown_q),
        .compareOutput     (compareBOutput)
    );

    // ------------------------------------------------------------
    // read data, one cycle after the strobe
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            regRdata <= etc_pkg::RST_BYTE;
        end else if (regRead) begin
            unique case (regAddr)
                etc_pkg::ADDR_CTRL_A: regRdata <= timerControlA_q;
                etc_pkg::ADDR_CTRL_B: regRdata <= timerControlB_q;
                etc_pkg::ADDR_COUNT:  regRdata <= counterValue_q;
                etc_pkg::ADDR_CMP_A:  regRdata <= compareABuf_q;
                etc_pkg::ADDR_CMP_B:  regRdata <= compareBBuf_q;
                etc_pkg::ADDR_MASK:   regRdata <= {5'h00, timerMask_q};
                etc_pkg::ADDR_FLAG:   regRdata <= {5'h00, timerFlag_q};
                default:              regRdata <= 8'h00;
            endcase
        end else begin
            regRdata <= 8'h00;
        end
    end

endmodule : etc_timer_core

/* File: rtl/etc_waveform.sv */
// waveform generator for one compare output
// match from the counter core is not qualified with the timer tick; it is gated with tick here
module etc_waveform (
    // clock and reset
    input  wire logic                  clk,
    input  wire logic                  nrst,
    // mode
    input  wire logic [2:0]            waveformModeField,
    input  etc_pkg::etc_unit_type      unitIn,
    input  wire logic                  tick,
    input  wire logic                  atTop,
    input  wire logic                  atBottom,
    input  wire logic                  countDown,
    // pin
    output logic                       compareOutput
);

    logic pwmFast;
    logic pwmPhase;
    logic comOn;

    assign pwmFast  = waveformModeField[1:0] == 2'b11;
    assign pwmPhase = waveformModeField[1:0] == 2'b01;
    assign comOn    = unitIn.com[1];

    // ------------------------------------------------------------
    // output state
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            compareOutput <= 1'b0;
        end else if (pwmFast) begin
            if (tick && unitIn.match && comOn) begin
                compareOutput <= unitIn.com[0];
            end else if (tick && atBottom && comOn) begin
                compareOutput <= ~unitIn.com[0];
            end
        end else if (pwmPhase) begin
            if (tick && unitIn.match && comOn) begin
                compareOutput <= unitIn.com[0] ^ countDown;
            end else if (tick && atTop && comOn && !unitIn.match) begin
                compareOutput <= compareOutput;
            end
        end else if ((tick && unitIn.match) || unitIn.force_hit) begin
            unique case (unitIn.com)
                2'b00: compareOutput <= compareOutput;
                2'b01: compareOutput <= ~compareOutput;
                2'b10: compareOutput <= 1'b0;
                2'b11: compareOutput <= 1'b1;
            endcase
        end
    end

endmodule : etc_waveform

/* File: sim/etc_timer_core_sva.sv */
// checker for the timer/counter core register port and outputs
// assumes one clock domain, bound to etc_timer_core by the bind below
module etc_timer_core_sva (
    // clock and reset
    input wire logic       clk,
    input wire logic       nrst,
    // register port
    input wire logic [3:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic       regWrite,
    input wire logic       regRead,
    input wire logic [7:0] regRdata,
    // outputs
    input wire logic       compareAOutput,
    input wire logic       compareBOutput,
    input wire logic       overflowIrq,
    input wire logic       compareAIrq,
    input wire logic       compareBIrq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    rdata_idle_a: assert property (!$past(regRead) |-> regRdata == 8'h00)
        else $error("read data not zero outside read answer");
    cmp_readback_a: assert property (
        (regWrite && regAddr == etc_pkg::ADDR_CMP_A) ##2
        (regRead && regAddr == etc_pkg::ADDR_CMP_A)
        |=> regRdata == $past(regWdata, 3))
        else $error("compare A readback differs from written value");
    mask_ovf_a: assert property (
        regWrite && regAddr == etc_pkg::ADDR_MASK && !regWdata[0]
        |=> !overflowIrq)
        else $error("overflow request not masked");
    mask_cmpb_a: assert property (
        regWrite && regAddr == etc_pkg::ADDR_MASK && !regWdata[2]
        |=> !compareBIrq)
        else $error("compare B request not masked");
    flag_width_a: assert property (
        regRead && regAddr == etc_pkg::ADDR_FLAG |=> regRdata[7:3] == 5'h0)
        else $error("unused flag bits read nonzero");
    ctrl_b_rsvd_a: assert property (
        regRead && regAddr == etc_pkg::ADDR_CTRL_B |=> regRdata[7:4] == 4'h0)
        else $error("control B upper bits read nonzero");
    unmapped_zero_a: assert property (
        regRead && regAddr > etc_pkg::ADDR_FLAG |=> regRdata == 8'h00)
        else $error("unmapped read nonzero");
    reset_quiet_a: assert property (
        $rose(nrst) |-> !compareAOutput && !compareBOutput && !overflowIrq
        && !compareAIrq && !compareBIrq)
        else $error("outputs active right after reset");
    irq_hold_a: assert property ($fell(compareAIrq) |-> $past(regWrite))
        else $error("compare A request dropped without a write");
endmodule : etc_timer_core_sva

bind etc_timer_core etc_timer_core_sva i_etc_timer_core_sva (
    .clk(clk), .nrst(nrst), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
    .compareAOutput(compareAOutput), .compareBOutput(compareBOutput),
    .overflowIrq(overflowIrq), .compareAIrq(compareAIrq),
    .compareBIrq(compareBIrq)
);

/* File: sim/testbench.sv */
// self-checking bench for the timer/counter core
// assumes the package and core are compiled first, checker bound
module testbench;
    timeunit 1ns;
    timeprecision 1ns;

    // ------------------------------------------------------------
    // signals and instance
    // ------------------------------------------------------------
    logic       clk, nrst, regWrite, regRead, extCount;
    logic       compareAOutput, compareBOutput;
    logic       overflowIrq, compareAIrq, compareBIrq;
    logic [3:0] regAddr;
    logic [7:0] regWdata, regRdata, v;
    logic [1:0] o;
    int         miscompares = 0;
    int         n_checks = 0;

    etc_timer_core i_etc_timer_core (
        .clk(clk), .nrst(nrst), .regAddr(regAddr), .regWdata(regWdata),
        .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
        .externalCountInput(extCount), .compareAOutput(compareAOutput),
        .compareBOutput(compareBOutput), .overflowIrq(overflowIrq),
        .compareAIrq(compareAIrq), .compareBIrq(compareBIrq));

    always #50 clk = ~clk;

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
            miscompares++;
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        regWrite <= 1'b1; regAddr <= a; regWdata <= d;
        @(posedge clk);
        regWrite <= 1'b0;
    endtask : wr
    task automatic rdv(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        regRead <= 1'b1; regAddr <= a;
        @(posedge clk);
        regRead <= 1'b0;
        @(negedge clk);
        d = regRdata;
    endtask : rdv
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        logic [7:0] d;
        rdv(a, d);
        chk(d, e);
    endtask : rd
    task automatic irq(input logic [2:0] e);
        @(negedge clk);
        chk({5'h0, compareBIrq, compareAIrq, overflowIrq}, {5'h0, e});
    endtask : irq
    task automatic pulses(input int n);
        repeat (n) begin
            extCount <= 1'b1; tick(4); extCount <= 1'b0; tick(4);
        end
    endtask : pulses
    task automatic final_report;
        if (miscompares == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : final_report

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        clk = 0; nrst = 0; regAddr = 0; regWdata = 0;
        regWrite = 0; regRead = 0; extCount = 0;
        tick(4);
        nrst <= 1'b1;
        for (int a = 0; a < 8; a++) rd(a[3:0], 8'h00);
        wr(etc_pkg::ADDR_COUNT, 8'hA5);
        wr(etc_pkg::ADDR_CMP_B, 8'hC3);
        wr(etc_pkg::ADDR_CMP_A, 8'h5A);
        rd(etc_pkg::ADDR_CMP_A, 8'h5A);
        rd(etc_pkg::ADDR_CMP_B, 8'hC3);
        tick(20);
        rd(etc_pkg::ADDR_COUNT, 8'hA5);
        // overflow in normal mode
        wr(etc_pkg::ADDR_COUNT, 8'hFD);
        wr(etc_pkg::ADDR_CTRL_B, 8'h01); tick(8); wr(etc_pkg::ADDR_CTRL_B, 8'h00);
        rdv(etc_pkg::ADDR_FLAG, v); chk(v & 8'h01, 8'h01);
        wr(etc_pkg::ADDR_MASK, 8'h01); irq(3'b001);
        wr(etc_pkg::ADDR_FLAG, 8'h01); irq(3'b000);
        // both compare units
        wr(etc_pkg::ADDR_COUNT, 8'h10);
        wr(etc_pkg::ADDR_CMP_A, 8'h14); wr(etc_pkg::ADDR_CMP_B, 8'h12);
        wr(etc_pkg::ADDR_MASK, 8'h07);
        wr(etc_pkg::ADDR_CTRL_B, 8'h01); tick(10); wr(etc_pkg::ADDR_CTRL_B, 8'h00);
        irq(3'b110);
        rd(etc_pkg::ADDR_FLAG, 8'h06);
        wr(etc_pkg::ADDR_MASK, 8'h02); irq(3'b010);
        // counter write blocks the next match
        wr(etc_pkg::ADDR_FLAG, 8'h07); wr(etc_pkg::ADDR_CMP_A, 8'h30);
        wr(etc_pkg::ADDR_COUNT, 8'h30);
        wr(etc_pkg::ADDR_CTRL_B, 8'h01); tick(3); wr(etc_pkg::ADDR_CTRL_B, 8'h00);
        rd(etc_pkg::ADDR_FLAG, 8'h00);
        // clear on compare A
        wr(etc_pkg::ADDR_COUNT, 8'h00); wr(etc_pkg::ADDR_CMP_A, 8'h05);
        wr(etc_pkg::ADDR_CTRL_A, 8'h42);
        wr(etc_pkg::ADDR_CTRL_B, 8'h01); tick(40); wr(etc_pkg::ADDR_CTRL_B, 8'h00);
        rdv(etc_pkg::ADDR_COUNT, v); chk({7'h0, v <= 8'h05}, 8'h01);
        rdv(etc_pkg::ADDR_FLAG, v); chk(v & 8'h03, 8'h02);
        // forced match toggles both pins
        wr(etc_pkg::ADDR_CTRL_A, 8'h50);
        @(negedge clk);
        o = {compareBOutput, compareAOutput};
        wr(etc_pkg::ADDR_CTRL_B, 8'hC0); tick(2);
        chk({6'h0, compareBOutput, compareAOutput}, {6'h0, ~o});
        rd(etc_pkg::ADDR_CTRL_B, 8'h00);
        // external count input, both edges
        wr(etc_pkg::ADDR_CTRL_A, 8'h00); wr(etc_pkg::ADDR_COUNT, 8'h00);
        wr(etc_pkg::ADDR_CTRL_B, 8'h07); pulses(3);
        wr(etc_pkg::ADDR_CTRL_B, 8'h06); pulses(2);
        wr(etc_pkg::ADDR_CTRL_B, 8'h00);
        rd(etc_pkg::ADDR_COUNT, 8'h05);
        // prescaled by eight
        wr(etc_pkg::ADDR_COUNT, 8'h00);
        wr(etc_pkg::ADDR_CTRL_B, 8'h02); tick(80); wr(etc_pkg::ADDR_CTRL_B, 8'h00);
        rdv(etc_pkg::ADDR_COUNT, v); chk({7'h0, v >= 8'h09 && v <= 8'h0B}, 8'h01);
        // write while counting
        wr(etc_pkg::ADDR_CTRL_B, 8'h01); wr(etc_pkg::ADDR_COUNT, 8'h80);
        rdv(etc_pkg::ADDR_COUNT, v); chk({7'h0, v == 8'h80 || v == 8'h81}, 8'h01);
        wr(etc_pkg::ADDR_CTRL_B, 8'h00);
        // phase correct: up to 0xFF, then back down
        wr(etc_pkg::ADDR_CTRL_A, 8'h01);
        wr(etc_pkg::ADDR_COUNT, 8'hFD);
        wr(etc_pkg::ADDR_CTRL_B, 8'h01);
        tick(4);
        wr(etc_pkg::ADDR_CTRL_B, 8'h00);
        rd(etc_pkg::ADDR_COUNT, 8'hFB);
        final_report();
    end

    initial begin
        #(100 * 5000);
        miscompares++;
        final_report();
    end
endmodule : testbench
